// ### logic/alu_if.sv
interface alu_if;
    logic [15:0] instr;
    logic [7:0]  acc;
    logic [7:0]  operand;
    logic [4:0]  flagsIn;
    logic [7:0]  result;
    logic [4:0]  flagsOut;
    logic        toAcc;
    logic        toMem;

    modport alu (
        input  instr, acc, operand, flagsIn,
        output result, flagsOut, toAcc, toMem
    );
    modport core (
        output instr, acc, operand, flagsIn,
        input  result, flagsOut, toAcc, toMem
    );
endinterface : alu_if

// ### logic/alu_pkg.sv
package alu_pkg;

    // Bus word offsets (byte addresses)
    localparam logic [11:0] OFS_INSTR  = 12'h000;
    localparam logic [11:0] OFS_ACC    = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_BANK   = 12'h00c;
    localparam logic [11:0] OFS_COUNT  = 12'h010;
    localparam int          MEM_SEL_BIT = 11;   // Upper half: data memory

    // Data memory shape: banks of 256 bytes
    localparam int BANK_W   = 1;
    localparam int MEM_AW   = BANK_W + 8;
    localparam int MEM_SIZE = 1 << MEM_AW;

    // Status field positions
    localparam int FLG_C   = 0;
    localparam int FLG_HC  = 1;
    localparam int FLG_Z   = 2;
    localparam int FLG_VF  = 3;
    localparam int FLG_N   = 4;
    localparam int FLG_BAD = 8;   // Sticky unknown-opcode flag

    // Reset values
    localparam logic [7:0]        ACC_RST    = 8'h00;
    localparam logic [4:0]        STATUS_RST = 5'h00;
    localparam logic [BANK_W-1:0] BANK_RST   = '0;
    localparam logic [15:0]       INSTR_RST  = 16'h0000;

    // Opcodes and instruction fields
    localparam logic [15:0] OPC_ADJ    = 16'h0007;
    localparam logic [5:0]  OPC_DEC    = 6'h01;    // Bits 15:10
    localparam logic [7:0]  OPC_LITSUB = 8'h08;    // Bits 15:8
    localparam int          FLD_DEST   = 9;
    localparam int          FLD_ACCESS = 8;

    // Decimal adjust constants
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [3:0] BCD_FIX = 4'h6;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_ADJ,
        OP_DEC,
        OP_LITSUB
    } op_kind_e;

    // Opcode decode, shared by the core and the ALU
    function automatic op_kind_e decodeOp(input logic [15:0] instr);
        if (instr == OPC_ADJ) begin
            return OP_ADJ;
        end else if (instr[15:10] == OPC_DEC) begin
            return OP_DEC;
        end else if (instr[15:8] == OPC_LITSUB) begin
            return OP_LITSUB;
        end
        return OP_NONE;
    endfunction : decodeOp

endpackage : alu_pkg

// ### logic/alu_unit.sv
module alu_unit
    import alu_pkg::*;
(
    // Operands and results
    alu_if.alu bus
);
    op_kind_e   kind;
    logic [8:0] lowFix;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] k;

    assign kind = decodeOp(bus.instr);
    assign k    = bus.instr[7:0];

    ////////////////////////////////////////////////////////////////////
    // Result and flags; flags not touched keep their input value
    always_comb begin
        lowFix       = 9'h000;
        sum          = 9'h000;
        nib          = 5'h00;
        bus.result   = bus.acc;
        bus.flagsOut = bus.flagsIn;
        bus.toAcc    = 1'b0;
        bus.toMem    = 1'b0;
        case (kind)
            OP_ADJ: begin
                // Low nibble first, so its carry reaches the high one
                lowFix = {1'b0, bus.acc};
                if (bus.acc[3:0] > BCD_MAX || bus.flagsIn[FLG_HC]) begin
                    lowFix = {1'b0, bus.acc} + {5'h00, BCD_FIX};
                end
                sum = lowFix;
                if (lowFix[7:4] > BCD_MAX || bus.flagsIn[FLG_C]) begin
                    sum = lowFix + {1'b0, BCD_FIX, 4'h0};
                end
                bus.result = sum[7:0];
                bus.flagsOut[FLG_C] = bus.flagsIn[FLG_C] | sum[8]
                                    | lowFix[8];
                bus.toAcc = 1'b1;
            end
            OP_DEC: begin
                bus.result = bus.operand - 8'h01;
                bus.flagsOut[FLG_C]  = bus.operand != 8'h00;
                bus.flagsOut[FLG_HC] = bus.operand[3:0] != 4'h0;
                bus.flagsOut[FLG_N]  = bus.result[7];
                bus.flagsOut[FLG_VF] = bus.operand == 8'h80;
                bus.flagsOut[FLG_Z]  = bus.result == 8'h00;
                bus.toAcc = ~bus.instr[FLD_DEST];
                bus.toMem = bus.instr[FLD_DEST];
            end
            OP_LITSUB: begin
                // Two's complement: k + ~W + 1, carry means no borrow
                sum = {1'b0, k} + {1'b0, ~bus.acc} + 9'h001;
                nib = {1'b0, k[3:0]} + {1'b0, ~bus.acc[3:0]} + 5'h01;
                bus.result = sum[7:0];
                bus.flagsOut[FLG_C]  = sum[8];
                bus.flagsOut[FLG_HC] = nib[4];
                bus.flagsOut[FLG_N]  = sum[7];
                bus.flagsOut[FLG_VF] = (k[7] != bus.acc[7])
                                     && (sum[7] != k[7]);
                bus.flagsOut[FLG_Z]  = sum[7:0] == 8'h00;
                bus.toAcc = 1'b1;
            end
            default: begin
                bus.result = bus.acc;
            end
        endcase
    end

endmodule : alu_unit

// ### logic/bcd_alu_core.sv
// How it works
// - Decimal adjust adds 6 to low nibble if above 9 or half-carry set.
// - Decimal adjust adds 6 to high nibble if above 9 or carry; only C.
// - Decrement subtracts one in one cycle, updating all five flags.
// - Destination bit 0 writes accumulator, 1 writes back the register.
// - Access bit 0 maps the address into the fixed access bank.
// - Access bit 1 combines the address with the bank select value.
//
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
module bcd_alu_core
    import alu_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } state_e;

    state_e            state_ff;
    logic [7:0]        acc_ff;
    logic [4:0]        status_ff;
    logic              badOp_ff;
    logic [BANK_W-1:0] bank_ff;
    logic [15:0]       instr_ff;
    logic [15:0]       count_ff;
    logic [7:0]        mem_ff [MEM_SIZE];
    logic              ack_ff;
    logic              err_ff;
    logic [31:0]       rdat_ff;
    logic [31:0]       nxt_rdat;
    logic              req;
    logic              isMem;
    logic              hit;
    logic              wrReq;
    logic              execNow;
    op_kind_e          kind;
    logic [MEM_AW-1:0] memIdx;
    logic [MEM_AW-1:0] busIdx;
    logic [7:0]        operand;

    alu_if aluBus();
    alu_unit uAlu (.bus(aluBus.alu));

    ////////////////////////////////////////////////////////////////////
    // Bus decode; a new request waits until the last answer dropped
    assign req    = wb_cyc_i & wb_stb_i & ~ack_ff & ~err_ff;
    assign isMem  = wb_adr_i[MEM_SEL_BIT];
    assign busIdx = wb_adr_i[MEM_AW+1:2];
    assign hit    = isMem || wb_adr_i == OFS_INSTR || wb_adr_i == OFS_ACC
                  || wb_adr_i == OFS_STATUS || wb_adr_i == OFS_BANK
                  || wb_adr_i == OFS_COUNT;
    assign wrReq  = req & hit & wb_we_i;
    assign wb_ack_o = ack_ff;
    assign wb_err_o = err_ff;
    assign wb_dat_o = rdat_ff;

    // Answer one cycle after the request is seen
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            ack_ff <= req & hit;
            err_ff <= req & ~hit;
        end
    end

    // Read mux, captured with the request
    always_comb begin
        nxt_rdat = 32'h0000_0000;
        if (isMem) begin
            nxt_rdat[7:0] = mem_ff[busIdx];
        end else begin
            case (wb_adr_i)
                OFS_INSTR:  nxt_rdat[15:0] = instr_ff;
                OFS_ACC:    nxt_rdat[7:0]  = acc_ff;
                OFS_STATUS: nxt_rdat[8:0]  = {badOp_ff, 3'h0, status_ff};
                OFS_BANK:   nxt_rdat[BANK_W-1:0] = bank_ff;
                OFS_COUNT:  nxt_rdat[15:0] = count_ff;
                default:    nxt_rdat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdat_ff <= 32'h0000_0000;
        end else if (req & hit & ~wb_we_i) begin // Err keeps old data
            rdat_ff <= nxt_rdat;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Instruction issue: a write to INSTR runs it in the next cycle
    assign execNow = state_ff == ST_EXEC;
    assign kind    = decodeOp(instr_ff);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (wrReq && !isMem && wb_adr_i == OFS_INSTR
                        && wb_sel_i[1:0] == 2'b11) begin
                        state_ff <= ST_EXEC;
                    end
                end
                ST_EXEC: state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            instr_ff <= INSTR_RST;
        end else if (wrReq && !isMem && wb_adr_i == OFS_INSTR
                     && wb_sel_i[1:0] == 2'b11) begin
            instr_ff <= wb_dat_i[15:0];
        end
    end

    // Executed instruction count, visible to software
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count_ff <= 16'h0000;
        end else if (execNow) begin
            count_ff <= count_ff + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Operand address: access bank splits at 0x80, bottom and top bank
    assign memIdx = instr_ff[FLD_ACCESS]
                  ? {bank_ff, instr_ff[7:0]}
                  : {{BANK_W{instr_ff[7]}}, instr_ff[7:0]};
    assign operand = mem_ff[memIdx];

    assign aluBus.instr   = instr_ff;
    assign aluBus.acc     = acc_ff;
    assign aluBus.operand = operand;
    assign aluBus.flagsIn = status_ff;

    // Accumulator: execution beats bus, they never collide anyway
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            acc_ff <= ACC_RST;
        end else if (execNow && aluBus.toAcc) begin
            acc_ff <= aluBus.result;
        end else if (wrReq && !isMem && wb_adr_i == OFS_ACC
                     && wb_sel_i[0]) begin
            acc_ff <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            status_ff <= STATUS_RST;
        end else if (execNow) begin
            status_ff <= aluBus.flagsOut;
        end else if (wrReq && !isMem && wb_adr_i == OFS_STATUS
                     && wb_sel_i[0]) begin
            status_ff <= wb_dat_i[4:0];
        end
    end

    // Unknown opcode flag: write 1 clears, a new event wins the clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            badOp_ff <= 1'b0;
        end else begin
            badOp_ff <= (execNow && kind == OP_NONE)
                      | (badOp_ff & ~(wrReq && !isMem
                         && wb_adr_i == OFS_STATUS && wb_sel_i[1]
                         && wb_dat_i[FLG_BAD]));
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bank_ff <= BANK_RST;
        end else if (wrReq && !isMem && wb_adr_i == OFS_BANK
                     && wb_sel_i[0]) begin
            bank_ff <= wb_dat_i[BANK_W-1:0];
        end
    end

    // Data memory, no reset: contents are software's business
    always_ff @(posedge core_clk) begin
        if (execNow && aluBus.toMem) begin
            mem_ff[memIdx] <= aluBus.result;
        end else if (wrReq && isMem && wb_sel_i[0]) begin
            mem_ff[busIdx] <= wb_dat_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic [7:0] litVal;
    assign litVal = instr_ff[7:0];

    sequence seqIssueAdj;
        state_ff == ST_IDLE && wrReq && !isMem && wb_adr_i == OFS_INSTR
        && wb_sel_i[1:0] == 2'b11 && wb_dat_i[15:0] == OPC_ADJ;
    endsequence
    sequence seqRunOnce;
        execNow && kind == OP_ADJ ##1 state_ff == ST_IDLE;
    endsequence

    chk_adj_low_keep: assert property (
        (execNow && kind == OP_ADJ && !status_ff[FLG_HC]
         && acc_ff[3:0] <= BCD_MAX)
        |=> acc_ff[3:0] == $past(acc_ff[3:0]))
        else $error("low nibble changed without cause");
    chk_adj_only_carry: assert property (
        (execNow && kind == OP_ADJ)
        |=> status_ff[4:1] == $past(status_ff[4:1]) && !$fell(status_ff[0]))
        else $error("decimal adjust touched other flags");
    chk_adj_one_cycle: assert property (
        seqIssueAdj |=> seqRunOnce)
        else $error("decimal adjust not run in one cycle");
    chk_dec_flags: assert property (
        (execNow && kind == OP_DEC)
        |=> status_ff[FLG_Z] == ($past(operand) == 8'h01)
            && status_ff[FLG_C] == ($past(operand) != 8'h00))
        else $error("decrement flags wrong");
    chk_dec_to_acc: assert property (
        (execNow && kind == OP_DEC && !instr_ff[FLD_DEST])
        |=> acc_ff == $past(operand) - 8'h01)
        else $error("decrement result missing from accumulator");
    chk_access_bank: assert property (
        (kind == OP_DEC && !instr_ff[FLD_ACCESS])
        |-> memIdx[MEM_AW-1] == instr_ff[7]
            && memIdx[7:0] == instr_ff[7:0])
        else $error("access bank mapping wrong");
    chk_bank_select: assert property (
        (kind == OP_DEC && instr_ff[FLD_ACCESS])
        |-> memIdx[MEM_AW-1 -: BANK_W] == bank_ff
            && memIdx[7:0] == instr_ff[7:0])
        else $error("bank select ignored");
    chk_lit_sub_result: assert property (
        (execNow && kind == OP_LITSUB)
        |=> acc_ff == $past(litVal) - $past(acc_ff)
            && status_ff[FLG_C] == ($past(litVal) >= $past(acc_ff)))
        else $error("literal minus accumulator wrong");

endmodule : bcd_alu_core

// ### tb/bcd_alu_core_tb.sv
module bcd_alu_core_tb
    import alu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////
    // Clock, reset and bus signals
    logic        core_clk = 1'b0;
    logic        rst_n    = 1'b0;
    logic        wbCyc    = 1'b0;
    logic        wbStb    = 1'b0;
    logic        wbWe     = 1'b0;
    logic [11:0] wbAdr    = 12'h000;
    logic [3:0]  wbSel    = 4'h0;
    logic [31:0] wbDatI   = 32'h0000_0000;
    logic [31:0] wbDatO;
    logic        wbAck;
    logic        wbErr;
    int          failures  = 0;
    int          cmp_count = 0;
    int          cycles    = 0;
    int          expCount  = 0;

    // Half period of 10 ns gives 50 MHz
    always #10 core_clk = ~core_clk;

    bcd_alu_core dut (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wb_cyc_i (wbCyc),
        .wb_stb_i (wbStb),
        .wb_we_i  (wbWe),
        .wb_adr_i (wbAdr),
        .wb_sel_i (wbSel),
        .wb_dat_i (wbDatI),
        .wb_dat_o (wbDatO),
        .wb_ack_o (wbAck),
        .wb_err_o (wbErr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Verdict, reached from the main sequence or the hang guard
    task automatic summarize();
        if (failures == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            summarize();
        end
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Classic single cycle; held until ack or err is sampled at an edge
    task automatic xfer(input logic we, input logic [11:0] adr,
                        input logic [3:0] sel, input logic [31:0] dat,
                        output logic [31:0] q, output logic e);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= adr;
        wbSel  <= sel;
        wbDatI <= dat;
        @(posedge core_clk);
        // No own limit: the hang guard ends a wait that never answers
        while (wbAck !== 1'b1 && wbErr !== 1'b1) begin
            @(posedge core_clk);
        end
        q = wbDatO;
        e = wbErr;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe  <= 1'b0;
        // Idle cycle so cyc never rises in the same step it fell
        @(posedge core_clk);
    endtask : xfer

    task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, adr, 4'hf, dat, q, e);
    endtask : wr

    task automatic rdChk(input string what, input logic [11:0] adr,
                         input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        xfer(1'b0, adr, 4'hf, 32'h0000_0000, q, e);
        check(what, exp, q);
    endtask : rdChk

    task automatic exec(input logic [15:0] instr);
        wr(OFS_INSTR, {16'h0000, instr});
        expCount++;
    endtask : exec

    // Byte address of a data memory cell: {bank, f} as word index
    function automatic logic [11:0] memAdr(input logic bank,
                                           input logic [7:0] f);
        return {1'b1, bank, f, 2'b00};
    endfunction : memAdr

    // Status word from separate flag values
    function automatic logic [31:0] flg(input logic c, input logic hc,
                                        input logic z, input logic vf,
                                        input logic n);
        logic [31:0] s;
        s = 32'h0000_0000;
        s[FLG_C]  = c;
        s[FLG_HC] = hc;
        s[FLG_Z]  = z;
        s[FLG_VF] = vf;
        s[FLG_N]  = n;
        return s;
    endfunction : flg

    task automatic adjCase(input logic [7:0] a, input logic [31:0] s,
                           input logic [7:0] ea, input logic [31:0] es);
        wr(OFS_ACC, {24'h000000, a});
        wr(OFS_STATUS, s);
        exec(OPC_ADJ);
        rdChk("adj acc", OFS_ACC, {24'h000000, ea});
        rdChk("adj status", OFS_STATUS, es);
    endtask : adjCase

    task automatic subCase(input logic [7:0] k, input logic [7:0] w,
                           input logic [7:0] ea, input logic [31:0] es);
        wr(OFS_ACC, {24'h000000, w});
        // Preset flags so stale values cannot pass
        wr(OFS_STATUS, 32'h0000_001f);
        exec({OPC_LITSUB, k});
        rdChk("sub acc", OFS_ACC, {24'h000000, ea});
        rdChk("sub status", OFS_STATUS, es);
    endtask : subCase

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] q;
        logic        e;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rdChk("acc reset", OFS_ACC, 32'h0000_0000);
        rdChk("status reset", OFS_STATUS, 32'h0000_0000);
        rdChk("bank reset", OFS_BANK, 32'h0000_0000);
        rdChk("count reset", OFS_COUNT, 32'h0000_0000);
        // Decimal adjust: both nibbles, flag-driven and carry-in cases
        adjCase(8'ha5, 32'h0, 8'h05, flg(1, 0, 0, 0, 0));
        adjCase(8'hce, 32'h0, 8'h34, flg(1, 0, 0, 0, 0));
        adjCase(8'h12, flg(0,1,0,0,0), 8'h18, flg(0,1,0,0,0));
        adjCase(8'h12, flg(1,0,0,0,0), 8'h72, flg(1,0,0,0,0));
        adjCase(8'h99, 32'h0, 8'h99, 32'h0);
        // Decrement: banks, access bank split, destinations
        wr(OFS_BANK, 32'h1);
        wr(memAdr(1'b1, 8'h10), 32'h01);
        wr(memAdr(1'b0, 8'h10), 32'h55);
        wr(memAdr(1'b1, 8'h90), 32'h80);
        wr(memAdr(1'b0, 8'h20), 32'h00);
        wr(OFS_ACC, 32'haa);
        exec(16'h0710);
        rdChk("dec mem b1", memAdr(1'b1, 8'h10), 32'h00);
        rdChk("dec mem b0", memAdr(1'b0, 8'h10), 32'h55);
        rdChk("dec acc", OFS_ACC, 32'haa);
        rdChk("dec status", OFS_STATUS, flg(1, 1, 1, 0, 0));
        exec(16'h0410);
        rdChk("dec acc", OFS_ACC, 32'h54);
        rdChk("dec mem b0", memAdr(1'b0, 8'h10), 32'h55);
        rdChk("dec status", OFS_STATUS, flg(1, 1, 0, 0, 0));
        exec(16'h0690);
        rdChk("dec mem hi", memAdr(1'b1, 8'h90), 32'h7f);
        rdChk("dec status", OFS_STATUS, flg(1, 0, 0, 1, 0));
        wr(OFS_BANK, 32'h0);
        exec(16'h0520);
        rdChk("dec acc", OFS_ACC, 32'hff);
        rdChk("dec status", OFS_STATUS, flg(0, 0, 0, 0, 1));
        // Literal minus accumulator: positive, zero, negative, overflow
        subCase(8'h02, 8'h01, 8'h01, flg(1, 1, 0, 0, 0));
        subCase(8'h02, 8'h02, 8'h00, flg(1, 1, 1, 0, 0));
        subCase(8'h02, 8'h03, 8'hff, flg(0, 0, 0, 0, 1));
        subCase(8'h80, 8'h01, 8'h7f, flg(1, 0, 0, 1, 0));
        // Partial lane write must not run anything
        wr(OFS_ACC, 32'h33);
        wr(OFS_STATUS, 32'h0);
        xfer(1'b1, OFS_INSTR, 4'h1, 32'h0007, q, e);
        rdChk("partial acc", OFS_ACC, 32'h33);
        rdChk("count", OFS_COUNT, 32'(expCount));
        // Unknown opcode only raises the sticky flag, but still counts
        exec(16'hffff);
        rdChk("bad acc", OFS_ACC, 32'h33);
        rdChk("bad status", OFS_STATUS, 32'h0000_0100);
        rdChk("bad count", OFS_COUNT, 32'(expCount));
        // Unmapped address answers with err, last read data stays
        xfer(1'b0, 12'h014, 4'hf, 32'h0, q, e);
        check("unmapped err", 32'h1, {31'h0, e});
        check("unmapped dat", 32'(expCount), q);
        // Writing 1 to the sticky bit clears it
        wr(OFS_STATUS, 32'h0000_0100);
        rdChk("bad clear", OFS_STATUS, 32'h0000_0000);
        summarize();
    end

endmodule : bcd_alu_core_tb
